// File: common/spie_pkg.sv
package spie_pkg;

  // ----------------------------------------------------------------
  // opcodes, shifted in msb first
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_SET_WEN  = 8'h06;
  localparam logic [7:0] OP_CLR_WEN  = 8'h04;
  localparam logic [7:0] OP_STAT_RD  = 8'h05;
  localparam logic [7:0] OP_STAT_WR  = 8'h01;
  localparam logic [7:0] OP_MEM_RD   = 8'h03;
  localparam logic [7:0] OP_MEM_WR   = 8'h02;

  // ----------------------------------------------------------------
  // rising-edge counts within a frame
  // ----------------------------------------------------------------
  localparam logic [5:0] CNT_ZERO    = 6'h00;
  localparam logic [5:0] CNT_ONE     = 6'h01;
  localparam logic [5:0] CNT_OP      = 6'h08;
  localparam logic [5:0] CNT_STAT    = 6'h10;
  localparam logic [5:0] CNT_ADDR    = 6'h18;
  localparam logic [5:0] CNT_BYTE    = 6'h20;
  localparam logic [5:0] CNT_WRAP    = 6'h19;
  localparam logic [2:0] BIT_ZERO    = 3'h0;

  // ----------------------------------------------------------------
  // storage and protection
  // ----------------------------------------------------------------
  localparam logic [7:0] MEM_INIT    = 8'hff;
  localparam logic [1:0] BP_NONE     = 2'h0;
  localparam logic [1:0] BP_QUARTER  = 2'h1;
  localparam logic [1:0] BP_HALF     = 2'h2;
  localparam logic [1:0] BP_ALL      = 2'h3;
  localparam logic [1:0] TOP_QUARTER = 2'h3;
  localparam int         ADDR_W      = 10;
  localparam int         PAGE_BYTES  = 32;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         CLK_SYS_MHZ   = 25;
  localparam int         WRITE_TIME_US = 5000;
  localparam int         WRITE_CYCLES  = WRITE_TIME_US * CLK_SYS_MHZ;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NONE, CMD_SET_WEN, CMD_CLR_WEN, CMD_STAT_WR, CMD_MEM_WR
  } spie_cmd_t;

  typedef enum logic [2:0] {
    L_OPCODE, L_SET_WEN, L_CLR_WEN, L_STAT_RD, L_STAT_WR, L_MEM_RD, L_MEM_WR, L_DEAD
  } spie_link_t;

  typedef struct packed {
    logic       status_write_disable;
    logic [2:0] zero;
    logic       block_protect_hi;
    logic       block_protect_lo;
    logic       write_enable_latch;
    logic       write_in_progress;
  } spie_status_t;

  localparam spie_status_t STATUS_INIT = '0;

  typedef struct packed {
    spie_cmd_t   cmd;
    logic [7:0]  stat;
    logic [15:0] addr;
  } spie_frame_t;

endpackage : spie_pkg

// File: core/spie_sync.sv
`timescale 1ns/1ps
`default_nettype none
module spie_sync #(
  parameter int WIDTH = 1
) (
  // clock
  input  wire logic             i_clk,
  // data
  input  wire logic [WIDTH-1:0] i_d,
  output var  logic [WIDTH-1:0] o_q
);
  logic [WIDTH-1:0] meta_q;

  // the first stage is read only by the second
  always_ff @(posedge i_clk) begin
    meta_q <= i_d;
    o_q    <= meta_q;
  end
endmodule : spie_sync
`default_nettype wire

// File: core/spie_timer.sv
`timescale 1ns/1ps
`default_nettype none
module spie_timer #(
  parameter int CYCLES = 2
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // control
  input  wire logic i_start,
  output var  logic o_busy,
  output var  logic o_done
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q, cnt_d;
  logic          busy_d, done_d;

  always_comb begin
    cnt_d  = cnt_q;
    busy_d = o_busy;
    done_d = 1'b0;
    if (i_start && !o_busy) begin
      busy_d = 1'b1;
      cnt_d  = '0;
    end else if (o_busy) begin
      if (cnt_q == LAST) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q + CW'(1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q  <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      o_busy <= busy_d;
      o_done <= done_d;
    end
  end
endmodule : spie_timer
`default_nettype wire

// File: core/spie_core.sv
// Notes on behaviour
// [RULE_01] chip select high deselects the device and floats the serial output
// [RULE_02] deselected without internal write means standby; internal write runs on
// [RULE_03] host gives a chip select falling edge before any opcode after power-up
// [RULE_04] serial input bits are sampled on rising serial clock
// [RULE_05] serial output bit changes on falling serial clock
// [RULE_06] hold pauses the transfer, floats output, ignores input and clock
// [RULE_07] host keeps chip select low throughout hold
// [RULE_08] write-protect input is always driven to a defined level
// [RULE_09] write-protect and block-protect bits guard memory and status against writes
// [RULE_10] memory bytes start as all ones
// [RULE_11] nonvolatile status bits start as zero
// [RULE_12] instruction starts after chip select falls; first eight clocks are opcode
// [RULE_13] opcode is one byte, msb first
// [RULE_14] unknown opcode deselects logically and ignores the rest of the frame
// [RULE_15] set and clear write enable opcodes are eight clocks, no address or data
// [RULE_16] status read shifts out status bits 7..0 on clocks 9 to 16
// [RULE_17] status write takes status bits 7..0 on clocks 9 to 16
// [RULE_18] memory read and write take 16-bit address high first, data from clock 25
// [RULE_19] status byte layout: disable b7, protect b3 b2, latch b1, busy b0
// [RULE_20] memory read address auto-increments and rolls over
// [RULE_21] host sets the write enable latch before memory or status writes
// [RULE_22] serial output drives only during read data clocks, floats otherwise
`timescale 1ns/1ps
`default_nettype none
module spie_core
  import spie_pkg::*;
#(
  parameter int MEM_ADDR_W   = spie_pkg::ADDR_W,
  parameter int PAGE         = spie_pkg::PAGE_BYTES,
  parameter int WRITE_CYCLES = spie_pkg::WRITE_CYCLES
) (
  // system clock and reset
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_sys_rst,
  // serial link
  input  wire logic                  i_spi_sck,
  input  wire logic                  i_spi_cs_n,
  input  wire logic                  i_spi_si,
  input  wire logic                  i_hold_n,
  input  wire logic                  i_wp_n,
  output var  logic                  o_so,
  output var  logic                  o_so_oe_n,
  // status
  output var  logic                  o_standby,
  output var  spie_pkg::spie_status_t o_status
);
  import spie_pkg::*;

  localparam int AW = MEM_ADDR_W;
  localparam int PW = $clog2(PAGE);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic spie_link_t decode_op(input logic [7:0] op, input logic busy);
    case (op)
      OP_STAT_RD: decode_op = L_STAT_RD;
      OP_SET_WEN: decode_op = busy ? L_DEAD : L_SET_WEN;
      OP_CLR_WEN: decode_op = busy ? L_DEAD : L_CLR_WEN;
      OP_STAT_WR: decode_op = busy ? L_DEAD : L_STAT_WR;
      OP_MEM_RD:  decode_op = busy ? L_DEAD : L_MEM_RD;
      OP_MEM_WR:  decode_op = busy ? L_DEAD : L_MEM_WR;
      default:    decode_op = L_DEAD;
    endcase
  endfunction : decode_op

  function automatic logic is_guarded(input logic [1:0] bp, input logic [AW-1:0] a);
    case (bp)
      BP_QUARTER: is_guarded = (a[AW-1:AW-2] == TOP_QUARTER);
      BP_HALF:    is_guarded = a[AW-1];
      BP_ALL:     is_guarded = 1'b1;
      default:    is_guarded = 1'b0;
    endcase
  endfunction : is_guarded

  // ----------------------------------------------------------------
  // shared state
  // ----------------------------------------------------------------
  logic [7:0]      mem_q [2**AW];
  logic [7:0]      mem_d [2**AW];
  spie_status_t    stat_q, stat_d;
  spie_status_t    stat_l;
  logic [7:0]      stat_l_raw;

  // link rising-edge state
  logic [5:0]      cnt_q, cnt_d;
  spie_link_t      op_q, op_d;
  logic [7:0]      sh_q, sh_d;
  logic [15:0]     addr_q, addr_d;
  logic [7:0]      stin_q, stin_d;
  logic [7:0]      wbuf_q [PAGE];
  logic [7:0]      wbuf_d [PAGE];
  logic [PAGE-1:0] wmask_q, wmask_d;
  spie_frame_t     frame_q, frame_d;
  logic            seq_q = 1'b0;
  logic            seq_d;

  // link falling-edge state
  logic [7:0]      rd_q, rd_d;
  logic            so_d, oe_n_d;

  // system-side state
  logic [2:0]      sys_s;
  logic            cs_s, seq_s, wp_s;
  logic            cs_prev_q, seen_q, seen_d;
  logic            status_write_op_q, status_write_op_d, standby_d, start_w;
  logic [2:0]      pend_q, pend_d;
  logic            tmr_busy, tmr_done;

  // ----------------------------------------------------------------
  // link: rising edge of the serial clock
  // ----------------------------------------------------------------
  // status bits change only between frames or slowly, so a two-flop copy
  // on the serial clock is current well before the first data bit
  spie_sync #(.WIDTH(8)) u_link_sync (
    .i_clk (i_spi_sck),
    .i_d   (stat_q),
    .o_q   (stat_l_raw)
  );
  assign stat_l = spie_status_t'(stat_l_raw);

  always_comb begin
    cnt_d   = cnt_q;
    op_d    = op_q;
    sh_d    = sh_q;
    addr_d  = addr_q;
    stin_d  = stin_q;
    wbuf_d  = wbuf_q;
    wmask_d = wmask_q;
    frame_d = frame_q;
    seq_d   = seq_q;
    if (i_hold_n) begin                                    // see [RULE_06]
      sh_d  = {sh_q[6:0], i_spi_si};                       // see [RULE_04] see [RULE_13]
      cnt_d = (cnt_q == CNT_BYTE) ? CNT_WRAP : cnt_q + CNT_ONE;
      if (cnt_q == CNT_ZERO) begin
        seq_d   = ~seq_q;                                  // see [RULE_03]
        wmask_d = '0;
      end
      case (op_q)
        L_OPCODE: begin
          if (cnt_d == CNT_OP) op_d = decode_op(sh_d, stat_l.write_in_progress); // see [RULE_12] see [RULE_14]
        end
        L_STAT_WR: begin
          if (cnt_d == CNT_STAT) stin_d = sh_d;            // see [RULE_17]
        end
        L_MEM_RD, L_MEM_WR: begin
          if (cnt_d == CNT_STAT) addr_d[15:8] = sh_d;      // see [RULE_18]
          if (cnt_d == CNT_ADDR) addr_d[7:0] = sh_d;
          if (cnt_d == CNT_BYTE) begin
            if (op_q == L_MEM_RD) begin
              addr_d = 16'(addr_q[AW-1:0] + AW'(1));       // see [RULE_20]
            end else begin
              wbuf_d[addr_q[PW-1:0]]  = sh_d;
              wmask_d[addr_q[PW-1:0]] = 1'b1;
              addr_d[PW-1:0]          = addr_q[PW-1:0] + PW'(1);
            end
          end
        end
        default: ;
      endcase
      // what the frame means if chip select rises before the next edge
      frame_d.stat = stin_d;
      frame_d.addr = addr_d;
      case (op_d)
        L_SET_WEN: frame_d.cmd = (cnt_d == CNT_OP)   ? CMD_SET_WEN : CMD_NONE; // see [RULE_15]
        L_CLR_WEN: frame_d.cmd = (cnt_d == CNT_OP)   ? CMD_CLR_WEN : CMD_NONE;
        L_STAT_WR: frame_d.cmd = (cnt_d == CNT_STAT) ? CMD_STAT_WR : CMD_NONE;
        L_MEM_WR:  frame_d.cmd = (cnt_d == CNT_BYTE) ? CMD_MEM_WR  : CMD_NONE;
        default:   frame_d.cmd = CMD_NONE;
      endcase
    end
  end

  // frame position is cleared by chip select itself, since the serial
  // clock may stop as soon as the frame ends
  always_ff @(posedge i_spi_sck or posedge i_spi_cs_n) begin
    if (i_spi_cs_n) begin                                  // see [RULE_12]
      cnt_q <= CNT_ZERO;
      op_q  <= L_OPCODE;
    end else begin
      cnt_q <= cnt_d;
      op_q  <= op_d;
    end
  end

  // the frame summary must survive deselection for the system side
  always_ff @(posedge i_spi_sck) begin
    sh_q    <= sh_d;
    addr_q  <= addr_d;
    stin_q  <= stin_d;
    wbuf_q  <= wbuf_d;
    wmask_q <= wmask_d;
    frame_q <= frame_d;
    seq_q   <= seq_d;
  end

  // ----------------------------------------------------------------
  // link: falling edge of the serial clock
  // ----------------------------------------------------------------
  always_comb begin
    logic       rd_phase;
    logic [7:0] byte_v;
    rd_phase = 1'b0;
    byte_v   = '0;
    rd_d     = rd_q;
    so_d     = o_so;
    oe_n_d   = 1'b1;                                       // see [RULE_22]
    if (i_hold_n) begin                                    // see [RULE_06]
      rd_phase = ((op_q == L_STAT_RD) && (cnt_q >= CNT_OP)) ||
                 ((op_q == L_MEM_RD) && (cnt_q >= CNT_ADDR));
      if (rd_phase) begin
        oe_n_d = 1'b0;
        if (cnt_q[2:0] == BIT_ZERO) begin
          byte_v = (op_q == L_STAT_RD) ? stat_l : mem_q[addr_q[AW-1:0]]; // see [RULE_16] see [RULE_19]
          so_d   = byte_v[7];                              // see [RULE_05]
          rd_d   = {byte_v[6:0], 1'b0};
        end else begin
          so_d = rd_q[7];
          rd_d = {rd_q[6:0], 1'b0};
        end
      end
    end
  end

  // memory contents only change under an internal write, when reads are
  // refused, so the array is stable whenever this side looks at it
  always_ff @(negedge i_spi_sck or posedge i_spi_cs_n) begin
    if (i_spi_cs_n) begin                                  // see [RULE_01]
      rd_q      <= '0;
      o_so      <= 1'b0;
      o_so_oe_n <= 1'b1;
    end else begin
      rd_q      <= rd_d;
      o_so      <= so_d;
      o_so_oe_n <= oe_n_d;
    end
  end

  // ----------------------------------------------------------------
  // system side: command execution and internal write
  // ----------------------------------------------------------------
  spie_sync #(.WIDTH(3)) u_sys_sync (
    .i_clk (i_clk_sys),
    .i_d   ({i_spi_cs_n, seq_q, i_wp_n}),
    .o_q   (sys_s)
  );
  assign {cs_s, seq_s, wp_s} = sys_s;

  spie_timer #(.CYCLES(WRITE_CYCLES)) u_write_timer (
    .i_clk   (i_clk_sys),
    .i_rst   (i_sys_rst),
    .i_start (start_w),
    .o_busy  (tmr_busy),
    .o_done  (tmr_done)
  );

  always_comb begin
    logic take;
    take      = cs_s && !cs_prev_q && (seq_s != seen_q);
    mem_d     = mem_q;
    stat_d    = stat_q;
    pend_d    = pend_q;
    status_write_op_d    = status_write_op_q;
    seen_d    = take ? seq_s : seen_q;
    start_w   = 1'b0;
    if (take && !tmr_busy) begin
      case (frame_q.cmd)
        CMD_SET_WEN: stat_d.write_enable_latch = 1'b1;
        CMD_CLR_WEN: stat_d.write_enable_latch = 1'b0;
        CMD_STAT_WR: begin
          if (stat_q.write_enable_latch &&
              !(stat_q.status_write_disable && !wp_s)) begin // see [RULE_09]
            pend_d  = {frame_q.stat[7], frame_q.stat[3:2]};
            status_write_op_d  = 1'b1;
            start_w = 1'b1;
          end
        end
        CMD_MEM_WR: begin
          if (stat_q.write_enable_latch &&
              !is_guarded({stat_q.block_protect_hi, stat_q.block_protect_lo},
                          frame_q.addr[AW-1:0])) begin     // see [RULE_09]
            for (int i = 0; i < PAGE; i++) begin
              if (wmask_q[i]) mem_d[{frame_q.addr[AW-1:PW], PW'(i)}] = wbuf_q[i];
            end
            start_w = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (start_w) stat_d.write_in_progress = 1'b1;
    if (tmr_done) begin
      stat_d.write_in_progress  = 1'b0;
      stat_d.write_enable_latch = 1'b0;
      if (status_write_op_q) begin
        {stat_d.status_write_disable, stat_d.block_protect_hi,
         stat_d.block_protect_lo} = pend_q;
        status_write_op_d = 1'b0;
      end
    end
    standby_d = cs_s && !stat_d.write_in_progress;        // see [RULE_02]
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      for (int i = 0; i < 2**AW; i++) mem_q[i] <= MEM_INIT; // see [RULE_10]
      stat_q    <= STATUS_INIT;                            // see [RULE_11]
      pend_q    <= '0;
      status_write_op_q    <= 1'b0;
      cs_prev_q <= 1'b1;
      // constant so that an unknown synchroniser output cannot lock out commands
      seen_q    <= 1'b0;
      o_standby <= 1'b0;
    end else begin
      mem_q     <= mem_d;
      stat_q    <= stat_d;
      pend_q    <= pend_d;
      status_write_op_q    <= status_write_op_d;
      cs_prev_q <= cs_s;
      seen_q    <= seen_d;
      o_standby <= standby_d;
    end
  end

  assign o_status = stat_q;

endmodule : spie_core
`default_nettype wire

// File: bench/spie_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
module spie_core_sva
  import spie_pkg::*;
#(
  parameter int WRITE_CYCLES = 20
) (
  // system side
  input wire logic                   i_clk_sys,
  input wire logic                   i_sys_rst,
  input wire logic                   i_wp_n,
  input wire logic                   o_standby,
  input wire spie_pkg::spie_status_t o_status,
  // serial link
  input wire logic                   i_spi_sck,
  input wire logic                   i_spi_cs_n,
  input wire logic                   i_spi_si,
  input wire logic                   i_hold_n,
  input wire logic                   o_so,
  input wire logic                   o_so_oe_n
);
  // ----------------------------------------------------------------
  // frame tracking in the link domain
  // ----------------------------------------------------------------
  logic [5:0]  cnt_q;
  logic [7:0]  sh_q;
  logic [7:0]  op_q;
  logic        so_q;
  logic [15:0] busy_q;

  // held edges are not counted, matching what the device must ignore
  always_ff @(posedge i_spi_sck or posedge i_spi_cs_n) begin
    if (i_spi_cs_n) begin
      cnt_q <= 6'h00;
    end else if (i_hold_n) begin
      cnt_q <= cnt_q + {5'h00, cnt_q != 6'h3f};
      sh_q  <= {sh_q[6:0], i_spi_si};
      if (cnt_q == 6'h07) begin
        op_q <= {sh_q[6:0], i_spi_si};
      end
    end
  end

  always_ff @(posedge i_spi_sck) begin
    so_q <= o_so;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || !o_status.write_in_progress) begin
      busy_q <= 16'h0000;
    end else begin
      busy_q <= busy_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  cs_float_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_spi_cs_n |-> o_so_oe_n) else $error("output driven while deselected");
  so_edge_a: assert property (@(negedge i_spi_sck) disable iff (i_spi_cs_n)
    !o_so_oe_n |-> o_so == so_q) else $error("output moved while clock high");
  hold_float_a: assert property (@(negedge i_spi_sck) disable iff (i_spi_cs_n)
    !i_hold_n |=> o_so_oe_n) else $error("output driven during hold");
  op_quiet_a: assert property (@(posedge i_spi_sck) disable iff (i_spi_cs_n)
    cnt_q < 6'h08 |-> o_so_oe_n) else $error("output driven in opcode clocks");
  stat_drive_a: assert property (@(posedge i_spi_sck) disable iff (i_spi_cs_n)
    cnt_q >= 6'h08 && op_q == OP_STAT_RD && i_hold_n && $past(i_hold_n) |-> !o_so_oe_n)
    else $error("status bits not driven");
  read_drive_a: assert property (@(posedge i_spi_sck) disable iff (i_spi_cs_n)
    op_q == OP_MEM_RD && cnt_q >= 6'h08 && !o_status.write_in_progress && i_hold_n
    && $past(i_hold_n) |-> o_so_oe_n == (cnt_q < 6'h18)) else $error("read data window wrong");
  bad_op_a: assert property (@(posedge i_spi_sck) disable iff (i_spi_cs_n)
    cnt_q >= 6'h08 && op_q != OP_STAT_RD && op_q != OP_MEM_RD |-> o_so_oe_n)
    else $error("output driven after non-read opcode");
  standby_on_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_spi_cs_n[*5] ##0 (!o_status.write_in_progress)[*3] |=> o_standby)
    else $error("idle device not in standby");
  busy_on_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (o_status.write_in_progress)[*3] |-> !o_standby) else $error("standby during write");
  busy_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $rose(o_status.write_in_progress) |-> (o_status.write_in_progress)[*8])
    else $error("internal write cut short");
  busy_len_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    busy_q <= 16'(WRITE_CYCLES + 8)) else $error("internal write too long");
  stat_init_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $fell(i_sys_rst) |-> o_status == STATUS_INIT) else $error("status not cleared by reset");
  stat_zero_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    o_status.zero == 3'h0) else $error("unused status bits set");
endmodule : spie_core_sva
`default_nettype wire

// File: bench/spie_host.sv
`timescale 1ns/1ps
`default_nettype none
module spie_host (
  // link outputs
  output var logic o_sck,
  output var logic o_cs_n,
  output var logic o_si,
  output var logic o_hold_n,
  // link inputs
  input wire logic i_so,
  input wire logic i_so_oe_n
);
  logic so_w;

  // a floating line shows the inverse so a stale value never passes
  assign so_w = i_so_oe_n ? ~i_so : i_so;

  initial begin
    o_sck    = 1'b0;
    o_cs_n   = 1'b0;
    o_si     = 1'b0;
    o_hold_n = 1'b1;
    // a clean rising edge clears the link frame state, which has no reset
    #5 o_cs_n = 1'b1;
  end

  // clock stands low between frames; hold_at < 0 means no pause
  task automatic frame(input logic [39:0] tx, input int nbits, input int hold_at,
                       output logic [39:0] rx);
    rx     = '0;
    o_cs_n = 1'b0;
    #40;
    for (int i = 0; i < nbits; i++) begin
      if (i == hold_at) begin
        #10 o_hold_n = 1'b0;
        repeat (2) begin
          #32 o_sck = 1'b1;
          #32 o_sck = 1'b0;
          o_si = ~o_si;
        end
        #10 o_hold_n = 1'b1;
        #20;
      end
      o_si = tx[nbits-1-i];
      #32 o_sck = 1'b1;
      rx = {rx[38:0], so_w};
      #32 o_sck = 1'b0;
    end
    #40 o_cs_n = 1'b1;
    o_si = ~o_si;
    #200;
  endtask : frame
endmodule : spie_host
`default_nettype wire

// File: bench/spie_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module spie_core_tb;
  import spie_pkg::*;
  localparam int WC = 20;
  localparam int AW = 6;

  logic         clk_sys;
  logic         sys_rst;
  logic         wp_n;
  logic         sck;
  logic         cs_n;
  logic         si;
  logic         hold_n;
  logic         so;
  logic         so_oe_n;
  logic         standby;
  spie_status_t status;
  int           miscompares = 0;
  int           tests_run   = 0;
  logic [31:0]  seed        = 32'h0000ab0d;
  logic [7:0]   mem_m [64];
  logic [39:0]  rx;
  logic [7:0]   d;
  logic [5:0]   a;

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  spie_core #(.MEM_ADDR_W(AW), .WRITE_CYCLES(WC)) dut (
    .i_clk_sys(clk_sys), .i_sys_rst(sys_rst), .i_spi_sck(sck), .i_spi_cs_n(cs_n),
    .i_spi_si(si), .i_hold_n(hold_n), .i_wp_n(wp_n), .o_so(so), .o_so_oe_n(so_oe_n),
    .o_standby(standby), .o_status(status));

  spie_host host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .o_hold_n(hold_n),
                  .i_so(so), .i_so_oe_n(so_oe_n));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic summarize;
    if (miscompares == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  task automatic rd_stat(input logic [7:0] exp);
    host.frame(40'h0500, 16, -1, rx);
    chk("status byte", rx[7:0], exp);
  endtask : rd_stat

  // a dummy status read afterwards lets the link see the write end
  task automatic wait_idle(input logic busy);
    int n;
    n = 0;
    repeat (4) @(negedge clk_sys);
    chk("busy", {7'h00, status.write_in_progress}, {7'h00, busy});
    if (busy) chk("standby", {7'h00, standby}, 8'h00);
    while (status.write_in_progress !== 1'b0) begin
      @(negedge clk_sys);
      n++;
      if (n > 200) begin
        miscompares++;
        summarize();
      end
    end
    host.frame(40'h0500, 16, -1, rx);
  endtask : wait_idle

  task automatic wen_frame(input logic [31:0] tx, input int nb, input logic busy);
    host.frame(40'h06, 8, -1, rx);
    host.frame({8'h00, tx}, nb, -1, rx);
    wait_idle(busy);
  endtask : wen_frame

  task automatic rd(input logic [5:0] ad, output logic [7:0] q);
    host.frame({8'h00, OP_MEM_RD, 10'h000, ad, 8'h00}, 32, -1, rx);
    q = rx[7:0];
  endtask : rd

  initial begin
    sys_rst = 1'b1;
    wp_n    = 1'b1;
    foreach (mem_m[i]) mem_m[i] = MEM_INIT;
    repeat (2) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk("status port", status, 8'h00);
    chk("standby", {7'h00, standby}, 8'h01);
    chk("output enable", {7'h00, so_oe_n}, 8'h01);
    rd_stat(8'h00);
    rd(6'h15, d);
    chk("blank byte", d, 8'hff);
    // ----------------------------------------------------------------
    // latch set and clear, a nine-clock set frame and an unknown opcode
    // ----------------------------------------------------------------
    host.frame(40'h06, 8, -1, rx);
    rd_stat(8'h02);
    host.frame(40'h04, 8, -1, rx);
    rd_stat(8'h00);
    host.frame(40'h0c, 9, -1, rx);
    rd_stat(8'h00);
    host.frame(40'h0706, 16, -1, rx);
    rd_stat(8'h00);
    // ----------------------------------------------------------------
    // random writes with read back, top address first
    // ----------------------------------------------------------------
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      a    = (k == 0) ? 6'h3f : seed[5:0];
      mem_m[a] = seed[15:8];
      wen_frame({OP_MEM_WR, 10'h000, a, seed[15:8]}, 32, 1'b1);
      rd(a, d);
      chk("memory byte", d, mem_m[a]);
      rd_stat(8'h00);
    end
    host.frame({OP_MEM_RD, 16'h003f, 16'h0000}, 40, -1, rx);
    chk("last byte", rx[15:8], mem_m[63]);
    chk("wrapped byte", rx[7:0], mem_m[0]);
    // pause inside the address; output comes back only at a falling edge
    host.frame({8'h00, OP_MEM_RD, 16'h003f, 8'h00}, 32, 12, rx);
    chk("held read", rx[7:0], mem_m[63]);
    // ----------------------------------------------------------------
    // status write, then block and hardware protection
    // ----------------------------------------------------------------
    wen_frame({16'h0000, OP_STAT_WR, 8'hfc}, 16, 1'b1);
    rd_stat(8'h8c);
    seed = xs(seed);
    a    = seed[5:0];
    wen_frame({OP_MEM_WR, 10'h000, a, ~mem_m[a]}, 32, 1'b0);
    rd(a, d);
    chk("protected byte", d, mem_m[a]);
    @(negedge clk_sys);
    wp_n = 1'b0;
    wen_frame({16'h0000, OP_STAT_WR, 8'h00}, 16, 1'b0);
    rd_stat(8'h8e);
    @(negedge clk_sys);
    wp_n = 1'b1;
    wen_frame({16'h0000, OP_STAT_WR, 8'h00}, 16, 1'b1);
    rd_stat(8'h00);
    summarize();
  end
endmodule : spie_core_tb

bind spie_core spie_core_sva #(.WRITE_CYCLES(WRITE_CYCLES)) u_sva (
  .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_wp_n(i_wp_n), .o_standby(o_standby),
  .o_status(o_status), .i_spi_sck(i_spi_sck), .i_spi_cs_n(i_spi_cs_n), .i_spi_si(i_spi_si),
  .i_hold_n(i_hold_n), .o_so(o_so), .o_so_oe_n(o_so_oe_n));
`default_nettype wire
